// File: verilog/dbirq_regs.vh
// register offsets, field positions, reset values for the buffer event mask block
// How it works
// R1: mask bits 20 and 19 pass buffer 2 level-mark events to summary b.
// R2: mask bit 17 passes buffer 2 full event to summary b; zero blocks it.
// R3: mask bit 16 passes buffer 2 empty event; it resets to one.
// R4: mask bit 15 passes buffer 1 cell-confirm event to summary a.
// R5: mask bits 14 and 13 pass buffer 1 stamp release and expiry events.
// R6: mask bits 12 and 11 pass buffer 1 upper and lower level-mark events.
// R7: mask bits 9 and 8 pass buffer 1 full and empty events.
// R8: mask bit 7 passes buffer 0 cell-confirm event to summary a.
// R9: mask bit 6 passes buffer 0 stamp release event.
// R10: mask bit 5 passes buffer 0 stamp expiry event.
// R11: mask bits 4 and 3 pass buffer 0 upper and lower level-mark events.
// R12: mask bits 1 and 0 pass buffer 0 full and empty events.
// R13: bits 18, 10 and 2 ignore writes and read as zero.
// R14: event bits set by hardware, cleared by reading, zero after reset.
// R15: level-mark event bits set only on a zero-to-one status change.
// R16: other mask bits reset to zero; summary is any event with mask set.
`ifndef DBIRQ_REGS_VH
`define DBIRQ_REGS_VH

// register offsets
`define DBIRQ_ADDR_W 12
`define DBIRQ_MASK_OFS 12'h150
`define DBIRQ_FLAGS_OFS 12'h14C
`define DBIRQ_SUMMARY_OFS 12'h158

// per-buffer field positions inside one byte
`define DBIRQ_F_CELL 7
`define DBIRQ_F_REL 6
`define DBIRQ_F_AGED 5
`define DBIRQ_F_WM1 4
`define DBIRQ_F_WM0 3
`define DBIRQ_F_RESERVED_BIT 2
`define DBIRQ_F_FULL 1
`define DBIRQ_F_EMPTY 0

// implemented bits: 20..0, writable mask
`define DBIRQ_W 21
`define DBIRQ_LIVE_BITS 21'h1BFBFB
`define DBIRQ_GROUP_A 21'h00FBFB
`define DBIRQ_GROUP_B 21'h1B0000
`define DBIRQ_MASK_RST 21'h010000
`define DBIRQ_FLAGS_RST 21'h000000

`endif

// File: verilog/dbirq_src.v
// event source for one data buffer: pulses and edge-detected status
`timescale 1ns/1ps
`include "dbirq_regs.vh"

module dbirq_src (
    // clock and control
    input wire clk_in,
    input wire rst_n_in,
    input wire ce_in,
    // one-cycle hardware event pulses
    input wire cell_confirm_in,
    input wire stamp_release_in,
    input wire stamp_expired_in,
    // buffer status levels
    input wire upper_level_mark_in,
    input wire lower_level_mark_in,
    input wire full_in,
    input wire empty_in,
    // set requests in event byte layout
    output wire [7:0] set_out
);

    reg wm1_ff;
    reg wm0_ff;
    reg full_ff;
    reg empty_ff;

    // remember previous status levels
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            wm1_ff <= 1'b0;
            wm0_ff <= 1'b0;
            full_ff <= 1'b0;
            empty_ff <= 1'b0;
        end else if (ce_in) begin
            wm1_ff <= upper_level_mark_in;
            wm0_ff <= lower_level_mark_in;
            full_ff <= full_in;
            empty_ff <= empty_in;
        end
    end

    // R14 hardware event sets
    assign set_out[`DBIRQ_F_CELL] = cell_confirm_in;
    assign set_out[`DBIRQ_F_REL] = stamp_release_in;
    assign set_out[`DBIRQ_F_AGED] = stamp_expired_in;
    // R15 rising edge only
    assign set_out[`DBIRQ_F_WM1] = upper_level_mark_in & ~wm1_ff;
    assign set_out[`DBIRQ_F_WM0] = lower_level_mark_in & ~wm0_ff;
    assign set_out[`DBIRQ_F_RESERVED_BIT] = 1'b0;
    // full and empty flag on entering the state
    assign set_out[`DBIRQ_F_FULL] = full_in & ~full_ff;
    assign set_out[`DBIRQ_F_EMPTY] = empty_in & ~empty_ff;

endmodule // dbirq_src

// File: verilog/dbirq_top.v
// buffer event flags, their interrupt mask and the two summary outputs
`timescale 1ns/1ps
`include "dbirq_regs.vh"

module dbirq_top (
    // clock, reset, enable
    input wire clk_in,
    input wire rst_n_in,
    input wire ce_in,

    // register port
    input wire [11:0] addr_in,
    input wire [31:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    output wire [31:0] rdata_out,

    // buffer 0 events and status
    input wire b0_cell_confirm_in,
    input wire b0_stamp_release_in,
    input wire b0_stamp_expired_in,
    input wire b0_upper_level_mark_in,
    input wire b0_lower_level_mark_in,
    input wire b0_full_in,
    input wire b0_empty_in,

    // buffer 1 events and status
    input wire b1_cell_confirm_in,
    input wire b1_stamp_release_in,
    input wire b1_stamp_expired_in,
    input wire b1_upper_level_mark_in,
    input wire b1_lower_level_mark_in,
    input wire b1_full_in,
    input wire b1_empty_in,

    // buffer 2 status
    input wire b2_upper_level_mark_in,
    input wire b2_lower_level_mark_in,
    input wire b2_full_in,
    input wire b2_empty_in,

    // summary interrupt bits
    output wire buffer_summary_irq_a_out,
    output wire buffer_summary_irq_b_out
);

    // any bit set in both vectors within a group
    function masked_any;
        input [20:0] flags;
        input [20:0] mask;
        input [20:0] group;
        begin
            masked_any = |(flags & mask & group);
        end
    endfunction

    // widen a 21-bit register to the bus word
    function [31:0] to_word;
        input [20:0] val;
        begin
            to_word = {11'h000, val};
        end
    endfunction

    // one register address match
    function addr_hit;
        input [11:0] addr;
        input [11:0] ofs;
        begin
            addr_hit = (addr == ofs);
        end
    endfunction

    // state
    reg [20:0] buffer_event_irq_mask_low_ff;
    reg [20:0] nxt_buffer_event_irq_mask_low;
    reg [20:0] buffer_event_flags_low_ff;
    reg [20:0] nxt_buffer_event_flags_low;
    reg [31:0] rdata_ff;
    reg [31:0] nxt_rdata;
    reg irq_a_ff;
    reg irq_b_ff;

    // set requests from the buffer sources
    wire [7:0] b0_set;
    wire [7:0] b1_set;
    wire [7:0] b2_set;
    wire [20:0] hw_set;

    // address decode
    wire hit_mask;
    wire hit_flags;
    wire hit_summary;
    wire mask_wr;
    wire flags_rd;
    wire [20:0] rd_clear;

    // enable fields of the mask register
    wire b2_upper_level_mark_en;
    wire b2_lower_level_mark_en;
    wire b2_full_en;
    wire b2_empty_en;
    wire b1_cell_confirm_en;
    wire b1_stamp_release_en;
    wire b1_stamp_expired_en;
    wire b1_upper_level_mark_en;
    wire b1_lower_level_mark_en;
    wire b1_full_en;
    wire b1_empty_en;
    wire b0_cell_confirm_en;
    wire b0_stamp_release_en;
    wire b0_stamp_expired_en;
    wire b0_upper_level_mark_en;
    wire b0_lower_level_mark_en;
    wire b0_full_en;
    wire b0_empty_en;
    // enable fields back in register order
    wire [20:0] mask_fields;

    // read source codes, one-hot
    localparam [3:0] SRC_NONE = 4'b0001;
    localparam [3:0] SRC_MASK = 4'b0010;
    localparam [3:0] SRC_FLAGS = 4'b0100;
    localparam [3:0] SRC_SUMMARY = 4'b1000;
    // source picked by the current read strobe
    reg [3:0] rd_src;

    // buffer 0 event source
    dbirq_src u_src_b0 (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .ce_in(ce_in),
        .cell_confirm_in(b0_cell_confirm_in),
        .stamp_release_in(b0_stamp_release_in),
        .stamp_expired_in(b0_stamp_expired_in),
        .upper_level_mark_in(b0_upper_level_mark_in),
        .lower_level_mark_in(b0_lower_level_mark_in),
        .full_in(b0_full_in),
        .empty_in(b0_empty_in),
        .set_out(b0_set)
    );

    // buffer 1 event source
    dbirq_src u_src_b1 (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .ce_in(ce_in),
        .cell_confirm_in(b1_cell_confirm_in),
        .stamp_release_in(b1_stamp_release_in),
        .stamp_expired_in(b1_stamp_expired_in),
        .upper_level_mark_in(b1_upper_level_mark_in),
        .lower_level_mark_in(b1_lower_level_mark_in),
        .full_in(b1_full_in),
        .empty_in(b1_empty_in),
        .set_out(b1_set)
    );

    // buffer 2 event source, pulses outside this register half
    dbirq_src u_src_b2 (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .ce_in(ce_in),
        .cell_confirm_in(1'b0),
        .stamp_release_in(1'b0),
        .stamp_expired_in(1'b0),
        .upper_level_mark_in(b2_upper_level_mark_in),
        .lower_level_mark_in(b2_lower_level_mark_in),
        .full_in(b2_full_in),
        .empty_in(b2_empty_in),
        .set_out(b2_set)
    );

    // gather sets, reserved positions forced low
    // R13 reserved never set
    assign hw_set = {b2_set[4:0], b1_set, b0_set} & `DBIRQ_LIVE_BITS;

    // decode
    assign hit_mask = addr_hit(addr_in, `DBIRQ_MASK_OFS);
    assign hit_flags = addr_hit(addr_in, `DBIRQ_FLAGS_OFS);
    assign hit_summary = addr_hit(addr_in, `DBIRQ_SUMMARY_OFS);
    assign mask_wr = ce_in & wr_in & hit_mask;
    assign flags_rd = ce_in & rd_in & hit_flags;

    // R14 read clears what was returned
    assign rd_clear = flags_rd ? buffer_event_flags_low_ff : 21'h000000;

    // split the mask into its enable fields
    // buffer 2 fields
    // R1 level-mark enables
    assign b2_upper_level_mark_en = buffer_event_irq_mask_low_ff[16 + `DBIRQ_F_WM1];
    assign b2_lower_level_mark_en = buffer_event_irq_mask_low_ff[16 + `DBIRQ_F_WM0];
    // R2 full enable
    assign b2_full_en = buffer_event_irq_mask_low_ff[16 + `DBIRQ_F_FULL];
    // R3 empty enable
    assign b2_empty_en = buffer_event_irq_mask_low_ff[16 + `DBIRQ_F_EMPTY];

    // buffer 1 fields
    // R4 cell-confirm enable
    assign b1_cell_confirm_en = buffer_event_irq_mask_low_ff[8 + `DBIRQ_F_CELL];
    // R5 stamp enables
    assign b1_stamp_release_en = buffer_event_irq_mask_low_ff[8 + `DBIRQ_F_REL];
    assign b1_stamp_expired_en = buffer_event_irq_mask_low_ff[8 + `DBIRQ_F_AGED];
    // R6 level-mark enables
    assign b1_upper_level_mark_en = buffer_event_irq_mask_low_ff[8 + `DBIRQ_F_WM1];
    assign b1_lower_level_mark_en = buffer_event_irq_mask_low_ff[8 + `DBIRQ_F_WM0];
    // R7 full and empty enables
    assign b1_full_en = buffer_event_irq_mask_low_ff[8 + `DBIRQ_F_FULL];
    assign b1_empty_en = buffer_event_irq_mask_low_ff[8 + `DBIRQ_F_EMPTY];

    // buffer 0 fields
    // R8 cell-confirm enable
    assign b0_cell_confirm_en = buffer_event_irq_mask_low_ff[`DBIRQ_F_CELL];
    // R9 release enable
    assign b0_stamp_release_en = buffer_event_irq_mask_low_ff[`DBIRQ_F_REL];
    // R10 expiry enable
    assign b0_stamp_expired_en = buffer_event_irq_mask_low_ff[`DBIRQ_F_AGED];
    // R11 level-mark enables
    assign b0_upper_level_mark_en = buffer_event_irq_mask_low_ff[`DBIRQ_F_WM1];
    assign b0_lower_level_mark_en = buffer_event_irq_mask_low_ff[`DBIRQ_F_WM0];
    // R12 full and empty enables
    assign b0_full_en = buffer_event_irq_mask_low_ff[`DBIRQ_F_FULL];
    assign b0_empty_en = buffer_event_irq_mask_low_ff[`DBIRQ_F_EMPTY];

    // enable fields back in register order
    // R13 reserved positions never enable
    assign mask_fields = {
        b2_upper_level_mark_en,
        b2_lower_level_mark_en,
        1'b0, // reserved
        b2_full_en,
        b2_empty_en,
        b1_cell_confirm_en,
        b1_stamp_release_en,
        b1_stamp_expired_en,
        b1_upper_level_mark_en,
        b1_lower_level_mark_en,
        1'b0, // reserved
        b1_full_en,
        b1_empty_en,
        b0_cell_confirm_en,
        b0_stamp_release_en,
        b0_stamp_expired_en,
        b0_upper_level_mark_en,
        b0_lower_level_mark_en,
        1'b0, // reserved
        b0_full_en,
        b0_empty_en
    };

    // mask next value
    always @* begin
        nxt_buffer_event_irq_mask_low = buffer_event_irq_mask_low_ff;
        if (mask_wr) begin
            // R13 writes ignored on reserved
            nxt_buffer_event_irq_mask_low = wdata_in[20:0] & `DBIRQ_LIVE_BITS;
        end
    end

    // event flags next value, a new set beats the read clear
    always @* begin
        nxt_buffer_event_flags_low = buffer_event_flags_low_ff;
        // R14 clear on read
        nxt_buffer_event_flags_low = nxt_buffer_event_flags_low & ~rd_clear;
        // R15 edge-based sets land here
        nxt_buffer_event_flags_low = nxt_buffer_event_flags_low | hw_set;
    end

    // pick the register a read strobe selects
    always @* begin
        rd_src = SRC_NONE;
        if (ce_in && rd_in) begin
            if (hit_mask) begin
                rd_src = SRC_MASK;
            end else if (hit_flags) begin
                rd_src = SRC_FLAGS;
            end else if (hit_summary) begin
                rd_src = SRC_SUMMARY;
            end
        end
    end

    // read data mux, answers in the next cycle
    always @* begin
        case (rd_src)
            SRC_MASK: begin
                // R13 reserved read as zero
                nxt_rdata = to_word(mask_fields);
            end
            SRC_FLAGS: begin
                nxt_rdata = to_word(buffer_event_flags_low_ff);
            end
            SRC_SUMMARY: begin
                nxt_rdata = {30'h00000000, irq_b_ff, irq_a_ff};
            end
            default: begin
                nxt_rdata = 32'h00000000;
            end
        endcase
    end

    // mask register
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            // R3 empty enable resets to one
            // R16 other mask bits reset low
            buffer_event_irq_mask_low_ff <= `DBIRQ_MASK_RST;
        end else if (ce_in) begin
            buffer_event_irq_mask_low_ff <= nxt_buffer_event_irq_mask_low;
        end
    end

    // event flag register
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            // R14 flags reset to zero
            buffer_event_flags_low_ff <= `DBIRQ_FLAGS_RST;
        end else if (ce_in) begin
            buffer_event_flags_low_ff <= nxt_buffer_event_flags_low;
        end
    end

    // read data register, zero outside a read answer
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            rdata_ff <= 32'h00000000;
        end else if (ce_in) begin
            rdata_ff <= nxt_rdata;
        end
    end

    // summary bits follow enabled flags
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            irq_a_ff <= 1'b0;
            irq_b_ff <= 1'b0;
        end else if (ce_in) begin
            // R4 R5 R6 R7 gate buffer 1
            // R8 R9 R10 R11 R12 gate buffer 0
            irq_a_ff <= masked_any(buffer_event_flags_low_ff, mask_fields, `DBIRQ_GROUP_A);
            // R1 R2 R3 gate buffer 2
            // R16 any enabled event
            irq_b_ff <= masked_any(buffer_event_flags_low_ff, mask_fields, `DBIRQ_GROUP_B);
        end
    end

    // outputs straight from flops
    assign rdata_out = rdata_ff;
    assign buffer_summary_irq_a_out = irq_a_ff;
    assign buffer_summary_irq_b_out = irq_b_ff;

endmodule // dbirq_top

// File: tb/dbirq_top_chk.sv
// checker for the buffer event mask block, bound to its top module
`timescale 1ns/1ps
module dbirq_top_chk (
    // clock and control
    input wire clk_in,
    input wire rst_n_in,
    input wire ce_in,
    // register port
    input wire [11:0] addr_in,
    input wire [31:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    input wire [31:0] rdata_out,
    // event sources
    input wire b0_cell_confirm_in,
    input wire b1_cell_confirm_in,
    input wire b0_upper_level_mark_in,
    input wire b2_empty_in,
    // summaries
    input wire buffer_summary_irq_a_out,
    input wire buffer_summary_irq_b_out
);
    reg [20:0] msk_ff;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // shadow of the mask as written by software
    always @(posedge clk_in) begin
        if (!rst_n_in) msk_ff <= 21'h010000;
        else if (ce_in && wr_in && addr_in == 12'h150) msk_ff <= wdata_in[20:0] & 21'h1BFBFB;
    end
    // register port answers
    a_rdata_idle_zero: assert property (ce_in && !rd_in |=> rdata_out == 32'h0)
        else $error("read data not zero outside a read answer");
    a_reserved_bit_read_zero: assert property (ce_in && rd_in && addr_in == 12'h150 |=>
        rdata_out[31:21] == 11'h0 && !rdata_out[18] && !rdata_out[10] && !rdata_out[2])
        else $error("reserved mask bits read nonzero");
    a_mask_write_read: assert property (ce_in && wr_in && addr_in == 12'h150 ##1
        ce_in && rd_in && addr_in == 12'h150 |=> rdata_out[20:0] == ($past(wdata_in[20:0], 2) & 21'h1BFBFB))
        else $error("mask read does not return written value");
    a_unmapped_read_zero: assert property (ce_in && rd_in && addr_in == 12'h154 |=> rdata_out == 32'h0)
        else $error("unmapped read nonzero");
    a_ce_low_freeze: assert property (!ce_in |=> $stable(rdata_out) && $stable(buffer_summary_irq_a_out))
        else $error("state moved with clock enable low");
    // event gating onto summaries
    a_b0_cell_irq: assert property (ce_in && !wr_in && b0_cell_confirm_in && msk_ff[7] ##1 ce_in
        |=> buffer_summary_irq_a_out) else $error("buffer 0 cell confirm did not raise summary a");
    a_b1_cell_irq: assert property (ce_in && !wr_in && b1_cell_confirm_in && msk_ff[15] ##1 ce_in
        |=> buffer_summary_irq_a_out) else $error("buffer 1 cell confirm did not raise summary a");
    a_b0_mark_edge: assert property (ce_in ##1 (ce_in && !wr_in && msk_ff[4] && $rose(b0_upper_level_mark_in))
        ##1 ce_in |=> buffer_summary_irq_a_out) else $error("buffer 0 level mark edge did not raise summary a");
    a_b2_empty_edge: assert property (ce_in ##1 (ce_in && !wr_in && msk_ff[16] && $rose(b2_empty_in))
        ##1 ce_in |=> buffer_summary_irq_b_out) else $error("buffer 2 empty edge did not raise summary b");
    // main scenarios reached
    c_irq_a_rise: cover property ($rose(buffer_summary_irq_a_out));
    c_irq_b_rise: cover property ($rose(buffer_summary_irq_b_out));
    c_flag_read: cover property (ce_in && rd_in && addr_in == 12'h14C ##1 rdata_out != 32'h0);
endmodule // dbirq_top_chk

bind dbirq_top dbirq_top_chk i_chk (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .b0_cell_confirm_in(b0_cell_confirm_in), .b1_cell_confirm_in(b1_cell_confirm_in),
    .b0_upper_level_mark_in(b0_upper_level_mark_in), .b2_empty_in(b2_empty_in),
    .buffer_summary_irq_a_out(buffer_summary_irq_a_out), .buffer_summary_irq_b_out(buffer_summary_irq_b_out));

// File: tb/dbirq_top_tb.sv
// random self-checking bench with a reference model of mask, flags and summaries
`timescale 1ns/1ps
`include "dbirq_regs.vh"
module dbirq_top_tb;
    reg clk_in = 1'b0;
    reg rst_n_in = 1'b0;
    reg ce_in = 1'b0;
    reg [11:0] addr_in = 12'h0;
    reg [31:0] wdata_in = 32'h0;
    reg wr_in = 1'b0;
    reg rd_in = 1'b0;
    reg [20:0] ev = 21'h0;
    wire [31:0] rdata_out;
    wire irq_a;
    wire irq_b;
    integer seed = 32'h01AD;
    integer error_cnt = 0;
    integer n_compared = 0;
    integer cyc = 0;
    integer op;
    reg [20:0] m_mask, m_flags, m_prev, set;
    reg m_a, m_b;
    reg [31:0] m_rd;
    reg [11:0] adr_tab [0:3];
    always #5 clk_in = ~clk_in;
    dbirq_top i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .b0_cell_confirm_in(ev[7]), .b0_stamp_release_in(ev[6]), .b0_stamp_expired_in(ev[5]),
        .b0_upper_level_mark_in(ev[4]), .b0_lower_level_mark_in(ev[3]), .b0_full_in(ev[1]), .b0_empty_in(ev[0]),
        .b1_cell_confirm_in(ev[15]), .b1_stamp_release_in(ev[14]), .b1_stamp_expired_in(ev[13]),
        .b1_upper_level_mark_in(ev[12]), .b1_lower_level_mark_in(ev[11]), .b1_full_in(ev[9]), .b1_empty_in(ev[8]),
        .b2_upper_level_mark_in(ev[20]), .b2_lower_level_mark_in(ev[19]), .b2_full_in(ev[17]),
        .b2_empty_in(ev[16]), .buffer_summary_irq_a_out(irq_a), .buffer_summary_irq_b_out(irq_b));
    // reference model, one step per enabled edge
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            {m_mask, m_flags, m_prev, m_a, m_b, m_rd} = {21'h010000, 21'h0, 21'h0, 1'b0, 1'b0, 32'h0};
        end else if (ce_in) begin
            m_rd = 32'h0;
            if (rd_in && addr_in == `DBIRQ_MASK_OFS) m_rd = {11'h0, m_mask};
            if (rd_in && addr_in == `DBIRQ_FLAGS_OFS) m_rd = {11'h0, m_flags};
            if (rd_in && addr_in == `DBIRQ_SUMMARY_OFS) m_rd = {30'h0, m_b, m_a};
            m_a = |(m_flags & m_mask & 21'h00FBFB);
            m_b = |(m_flags & m_mask & 21'h1B0000);
            if (rd_in && addr_in == `DBIRQ_FLAGS_OFS) m_flags = 21'h0;
            // pulses set always, levels only on a rising change
            set = (ev & 21'h00E0E0) | (ev & 21'h1B1B1B & ~m_prev);
            m_prev = ev & 21'h1B1B1B;
            m_flags = m_flags | set;
            if (wr_in && addr_in == `DBIRQ_MASK_OFS) m_mask = wdata_in[20:0] & 21'h1BFBFB;
        end
    end
    // compare one value against the model
    task check(input [8*6-1:0] nm, input [31:0] exp_v, input [31:0] got_v);
        begin
            n_compared = n_compared + 1;
            if (got_v !== exp_v) begin
                error_cnt = error_cnt + 1;
                $display("MISMATCH %0s expected %h seen %h", nm, exp_v, got_v);
            end
        end
    endtask
    // settled outputs checked every cycle out of reset
    always @(negedge clk_in) begin
        if (rst_n_in && cyc > 0) begin
            check("rdata", m_rd, rdata_out);
            check("irq_a", {31'h0, m_a}, {31'h0, irq_a});
            check("irq_b", {31'h0, m_b}, {31'h0, irq_b});
        end
    end
    task close_out;
        begin
            $display("compared %0d mismatches %0d", n_compared, error_cnt);
            if (error_cnt == 0 && n_compared > 0) $display("[ PASS ]");
            else $display("[ FAIL ]");
            $finish;
        end
    endtask
    // random bus traffic, events, enable gaps and a second reset
    initial begin
        adr_tab[0] = `DBIRQ_MASK_OFS;
        adr_tab[1] = `DBIRQ_FLAGS_OFS;
        adr_tab[2] = `DBIRQ_SUMMARY_OFS;
        adr_tab[3] = 12'h154;
        repeat (20) @(posedge clk_in);
        for (cyc = 1; cyc < 6000; cyc = cyc + 1) begin
            @(posedge clk_in);
            op = $random(seed) & 7;
            rst_n_in <= !(cyc == 3000 || cyc == 3001);
            ce_in <= (op != 7);
            wr_in <= (op < 2) && (cyc > 1);
            rd_in <= (op > 1 && op < 5) || (cyc == 1);
            addr_in <= (cyc == 1) ? `DBIRQ_MASK_OFS : adr_tab[$random(seed) & 3];
            wdata_in <= $random(seed) & $random(seed) & $random(seed);
            ev <= $random(seed) & $random(seed);
        end
        close_out;
    end
    // hang guard
    initial begin
        #100000;
        error_cnt = error_cnt + 1;
        close_out;
    end
endmodule // dbirq_top_tb
